/* aotr_params.svh */
`ifndef AOTR_PARAMS_SVH
`define AOTR_PARAMS_SVH

// ****************************************************************
// Register addresses on the serial port
// ****************************************************************
`define AOTR_ADDR_TIMING 7'h03
`define AOTR_ADDR_TERM_A 7'h04
`define AOTR_ADDR_TERM_B 7'h05

// ****************************************************************
// Reset values
// ****************************************************************
`define AOTR_RST_TIMING 8'h6d
`define AOTR_RST_TERM 6'h00
`define AOTR_RST_PIN_SYNC 3'h2

// ****************************************************************
// Field positions
// ****************************************************************
`define AOTR_BYPASS_BIT 7
`define AOTR_HALF_BIT 6
`define AOTR_CLK_LSB 3
`define AOTR_DATA_LSB 0
`define AOTR_FIELD_W 3
`define AOTR_TERM_W 6
`define AOTR_SKEW_RESERVED 3'h4

// ****************************************************************
// Serial frame
// ****************************************************************
`define AOTR_LAST_BIT 3'h7

`endif

/* aotr_pkg.sv */
package aotr_pkg;

    // One-hot termination strength selects
    typedef enum logic [4:0] {
        OHM_50 = 5'h01,
        OHM_75 = 5'h02,
        OHM_100 = 5'h04,
        OHM_150 = 5'h08,
        OHM_300 = 5'h10
    } aotr_ohms_t;

    // Skew in sixteenths of the clock period, two's complement
    typedef logic signed [2:0] aotr_skew_t;

    typedef struct packed {
        logic aligner_bypass;
        logic half_period_delay;
        aotr_skew_t out_clock_skew;
        aotr_skew_t data_skew;
    } aotr_timing_t;

    typedef struct packed {
        aotr_ohms_t output_clock_term;
        aotr_ohms_t data_term;
    } aotr_term_t;

    // Serial port sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CMD = 3'b010,
        ST_DATA = 3'b100
    } aotr_spi_state_t;

endpackage

/* aotr_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module aotr_pin_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic [W-1:0] i_pin,
    output logic [W-1:0] o_level
);

    // ****************************************************************
    // Three-stage capture per pin, level moves only when stages two and three agree
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic lvl_reg;
            // Stage one feeds stage two only, to keep metastability contained
            always_ff @(posedge i_core_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    s1_reg <= RST[g];
                    s2_reg <= RST[g];
                    s3_reg <= RST[g];
                    lvl_reg <= RST[g];
                end else if (i_clk_en) begin
                    s1_reg <= i_pin[g];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        lvl_reg <= s3_reg;
                    end
                end
            end
            assign o_level[g] = lvl_reg;
        end
    endgenerate

endmodule

`default_nettype wire

/* aotr_top.sv */
// Operation
// - Data skew code, 101 reset, 100 reserved
// - Channel A clock termination, 1xx 300 ohm
// - Channel A data termination, 1xx 300 ohm
// - Channel B clock termination, bits 7:6 ignored
// - Channel B data termination, same encoding
`timescale 1ns/1ps
`default_nettype none
`include "aotr_params.svh"

module aotr_top (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic i_spi_sclk,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_sdio,
    output logic o_spi_sdio,
    output logic o_spi_sdio_oe,
    output aotr_pkg::aotr_timing_t o_timing,
    output aotr_pkg::aotr_term_t o_chan_a_term,
    output aotr_pkg::aotr_term_t o_chan_b_term
);
    import aotr_pkg::*;

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    // Reserved code leaves the output at nominal rather than guessing
    // Codes 1xx count backwards: 101 is -1, 110 is -2, 111 is -3
    function automatic aotr_skew_t skew_of(input logic [2:0] code);
        if (code == `AOTR_SKEW_RESERVED) begin
            skew_of = 3'sh0;
        end else if (code[2]) begin
            skew_of = aotr_skew_t'(3'h0 - {1'b0, code[1:0]});
        end else begin
            skew_of = aotr_skew_t'(code);
        end
    endfunction

    function automatic aotr_ohms_t ohms_of(input logic [2:0] code);
        aotr_ohms_t r;
        r = OHM_300;
        if (!code[2]) begin
            unique case (code[1:0])
                2'h0: r = OHM_50;
                2'h1: r = OHM_75;
                2'h2: r = OHM_100;
                2'h3: r = OHM_150;
            endcase
        end
        ohms_of = r;
    endfunction

    // ****************************************************************
    // Pin capture
    // ****************************************************************
    logic [2:0] pins_lvl;
    logic sclk_lvl;
    logic cs_n_lvl;
    logic sdio_lvl;
    logic sclk_prev_reg;

    aotr_pin_sync #(.W(3), .RST(`AOTR_RST_PIN_SYNC)) u_sync (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en),
        .i_pin({i_spi_sclk, i_spi_cs_n, i_spi_sdio}),
        .o_level(pins_lvl)
    );

    // Filtered pin levels and clock edges
    assign sclk_lvl = pins_lvl[2];
    assign cs_n_lvl = pins_lvl[1];
    assign sdio_lvl = pins_lvl[0];

    logic sclk_rise;
    logic sclk_fall;
    assign sclk_rise = sclk_lvl & ~sclk_prev_reg;
    assign sclk_fall = ~sclk_lvl & sclk_prev_reg;

    // ****************************************************************
    // Serial frame sequencer
    // ****************************************************************
    aotr_spi_state_t state_reg;
    aotr_spi_state_t state_next;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic cmd_read_reg;
    logic [6:0] cmd_addr_reg;
    logic load_pend_reg;
    logic [7:0] rd_shift_reg;
    logic [7:0] rd_word;

    logic last_bit;
    logic cmd_done;
    logic wr_en;
    logic [7:0] wr_data;
    assign last_bit = sclk_rise && (bit_cnt_reg == `AOTR_LAST_BIT);
    assign cmd_done = (state_reg == ST_CMD) && last_bit;
    assign wr_en = (state_reg == ST_DATA) && last_bit && !cmd_read_reg;
    assign wr_data = {shift_reg[6:0], sdio_lvl};

    // Deselect sends every state to idle; deselect on the last rising edge still writes
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: state_next = cs_n_lvl ? ST_IDLE : ST_CMD;
            ST_CMD: state_next = cs_n_lvl ? ST_IDLE : (cmd_done ? ST_DATA : ST_CMD);
            ST_DATA: state_next = (cs_n_lvl || last_bit) ? ST_IDLE : ST_DATA;
        endcase
    end

    // State, edge history and bit counting
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= ST_IDLE;
            sclk_prev_reg <= 1'b0;
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
        end else if (i_clk_en) begin
            state_reg <= state_next;
            sclk_prev_reg <= sclk_lvl;
            if (state_reg == ST_IDLE || cs_n_lvl) begin
                bit_cnt_reg <= 3'h0;
            end else if (sclk_rise) begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                shift_reg <= wr_data;
            end
        end
    end

    // Command capture and read shifter; data changes on falling edges
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cmd_read_reg <= 1'b0;
            cmd_addr_reg <= 7'h00;
            load_pend_reg <= 1'b0;
            rd_shift_reg <= 8'h00;
        end else if (i_clk_en) begin
            load_pend_reg <= cmd_done;
            if (cmd_done) begin
                cmd_read_reg <= shift_reg[6];
                cmd_addr_reg <= {shift_reg[5:0], sdio_lvl};
            end
            if (load_pend_reg) begin
                rd_shift_reg <= rd_word;
            end else if (state_reg == ST_DATA && sclk_fall && bit_cnt_reg != 3'h0) begin
                rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
            end
        end
    end

    assign o_spi_sdio = rd_shift_reg[7];
    assign o_spi_sdio_oe = (state_reg == ST_DATA) && cmd_read_reg && !load_pend_reg;

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    logic [7:0] timing_reg;
    logic [5:0] term_a_reg;
    logic [5:0] term_b_reg;
    logic sel_timing;
    logic sel_a;
    logic sel_b;

    // Address decode; unmapped addresses read zero and drop writes
    assign sel_timing = (cmd_addr_reg == `AOTR_ADDR_TIMING);
    assign sel_a = (cmd_addr_reg == `AOTR_ADDR_TERM_A);
    assign sel_b = (cmd_addr_reg == `AOTR_ADDR_TERM_B);
    assign rd_word = sel_timing ? timing_reg :
                     sel_a ? {2'b00, term_a_reg} :
                     sel_b ? {2'b00, term_b_reg} : 8'h00;

    // Bits 7:6 of the termination registers are not stored
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            timing_reg <= `AOTR_RST_TIMING;
            term_a_reg <= `AOTR_RST_TERM;
            term_b_reg <= `AOTR_RST_TERM;
        end else if (i_clk_en && wr_en) begin
            if (sel_timing) begin
                timing_reg <= wr_data;
            end
            if (sel_a) begin
                term_a_reg <= wr_data[`AOTR_TERM_W-1:0];
            end
            if (sel_b) begin
                term_b_reg <= wr_data[`AOTR_TERM_W-1:0];
            end
        end
    end

    // ****************************************************************
    // Decoded controls to the output drivers
    // ****************************************************************
    aotr_timing_t timing_next;
    aotr_term_t term_a_next;
    aotr_term_t term_b_next;
    assign timing_next.aligner_bypass = timing_reg[`AOTR_BYPASS_BIT];
    assign timing_next.half_period_delay = timing_reg[`AOTR_HALF_BIT];
    assign timing_next.out_clock_skew = skew_of(timing_reg[`AOTR_CLK_LSB +: 3]);
    assign timing_next.data_skew = skew_of(timing_reg[`AOTR_DATA_LSB +: 3]);
    assign term_a_next.output_clock_term = ohms_of(term_a_reg[`AOTR_CLK_LSB +: 3]);
    assign term_a_next.data_term = ohms_of(term_a_reg[`AOTR_DATA_LSB +: 3]);
    assign term_b_next.output_clock_term = ohms_of(term_b_reg[`AOTR_CLK_LSB +: 3]);
    assign term_b_next.data_term = ohms_of(term_b_reg[`AOTR_DATA_LSB +: 3]);

    // Registered so the analog drivers see glitch-free selects
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_timing <= '{1'b0, 1'b1, 3'sh7, 3'sh7};
            o_chan_a_term <= '{OHM_50, OHM_50};
            o_chan_b_term <= '{OHM_50, OHM_50};
        end else if (i_clk_en) begin
            o_timing <= timing_next;
            o_chan_a_term <= term_a_next;
            o_chan_b_term <= term_b_next;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_write_b;
        i_clk_en && wr_en && sel_b;
    endsequence

    sequence s_hold_en;
        i_clk_en;
    endsequence

    a_data_skew_neg3: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (timing_reg[2:0] == 3'h7) ##0 s_hold_en |=> (o_timing.data_skew == -3'sd1 * 3))
        else $error("data skew code 111 not -3/16");
    a_chan_a_clk_300: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (term_a_reg[5] && i_clk_en) |=> (o_chan_a_term.output_clock_term == OHM_300))
        else $error("chan A clock term 1xx not 300 ohm");
    a_chan_a_data_150: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (term_a_reg[2:0] == 3'h3 && i_clk_en) |=> (o_chan_a_term.data_term == OHM_150))
        else $error("chan A data term 011 not 150 ohm");
    a_chan_b_write: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        s_write_b ##1 s_hold_en |=> (term_b_reg == $past(wr_data[5:0], 2)) &&
        (o_chan_b_term.output_clock_term == ($past(wr_data[5], 2) ? OHM_300 :
        aotr_ohms_t'(5'h01 << $past(wr_data[4:3], 2)))))
        else $error("chan B write not stored or decoded");
    a_chan_b_data_50: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (term_b_reg[2:0] == 3'h0 && i_clk_en) |=> (o_chan_b_term.data_term == OHM_50))
        else $error("chan B data term 000 not 50 ohm");
    a_clk_skew_neg1: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (timing_reg[5:3] == 3'h5 && i_clk_en) |=> (o_timing.out_clock_skew == -3'sd1))
        else $error("output clock skew code 101 not -1/16");

endmodule

`default_nettype wire

/* aotr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Host on the three-wire serial port
// ****************************************************************
module aotr_host_model (
    input wire logic i_core_clk,
    input wire logic i_clk_en,
    input wire logic i_sdio,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sdio,
    output logic o_rd_valid,
    output logic [7:0] o_rd_data
);
    localparam int PH = 8; // Phase length, enabled clocks
    logic drv;
    logic bit_q;
    logic noise;

    // Released line flips every clock so a stale bit never reads back
    assign o_sdio = drv ? bit_q : noise;

    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_rd_valid = 1'b0;
        o_rd_data = 8'h00;
        drv = 1'b1;
        bit_q = 1'b0;
        noise = 1'b0;
    end

    always @(posedge i_core_clk) begin
        noise <= ~noise;
    end

    task automatic wait_en(input int n);
        int k;
        for (k = 0; k < n; k++) begin
            @(posedge i_core_clk);
            while (!i_clk_en) @(posedge i_core_clk);
        end
    endtask

    // Whole frame, MSB first; nbits below 16 aborts by lifting select
    task automatic xfer(input logic [15:0] w, input int nbits);
        logic [7:0] rd;
        int i;
        rd = 8'h00;
        o_cs_n <= 1'b0;
        wait_en(PH);
        for (i = 15; i > 15 - nbits; i--) begin
            drv <= !(w[15] && i < 8);
            bit_q <= w[i];
            wait_en(PH);
            o_sclk <= 1'b1;
            if (i < 8) rd = {rd[6:0], i_sdio};
            wait_en(PH);
            o_sclk <= 1'b0;
        end
        wait_en(PH);
        o_cs_n <= 1'b1;
        drv <= 1'b1;
        if (w[15] && nbits == 16) begin
            o_rd_data <= rd;
            o_rd_valid <= 1'b1;
        end
        @(posedge i_core_clk);
        o_rd_valid <= 1'b0;
        wait_en(6); // Select gap between frames
    endtask
endmodule

`default_nettype wire

/* aotr_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "aotr_params.svh"

module aotr_top_tb;
    import aotr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en = 1'b1;
    logic chk = 1'b0;
    logic sclk, cs_n, h_sdio, sdio, d_sdio, oe, rd_valid;
    logic [7:0] rd_data;
    aotr_timing_t timing;
    aotr_term_t term_a, term_b;
    logic [31:0] seed = 32'hc15c22d9;
    logic [7:0] sh [0:127];
    logic [7:0] q_rd [$];
    logic [27:0] q_out [$];
    int n_mismatch = 0;
    int n_compared = 0;

    always #12.5 clk = ~clk;
    assign sdio = oe ? d_sdio : h_sdio; // Wire level from both drivers

    aotr_top aotr_top_inst (.i_core_clk(clk), .i_reset_n(rst_n), .i_clk_en(en),
        .i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .i_spi_sdio(sdio), .o_spi_sdio(d_sdio),
        .o_spi_sdio_oe(oe), .o_timing(timing), .o_chan_a_term(term_a),
        .o_chan_b_term(term_b));
    aotr_host_model aotr_host_model_inst (.i_core_clk(clk), .i_clk_en(en),
        .i_sdio(sdio), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdio(h_sdio),
        .o_rd_valid(rd_valid), .o_rd_data(rd_data));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Enable stalls a quarter of the time to stretch every count
    always @(posedge clk) begin
        en <= (xs() & 32'h3) != 32'h0;
    end

    // 0xx adds sixteenths, 1xx subtracts them; the reserved 100 gives nominal
    function automatic aotr_skew_t skew(input logic [2:0] c);
        return c[2] ? -aotr_skew_t'({1'b0, c[1:0]}) : aotr_skew_t'(c);
    endfunction

    // Legal skew codes only, the host never writes the reserved 100
    function automatic logic [2:0] vcode(input int n);
        return 3'(n + (n > 3));
    endfunction

    function automatic aotr_ohms_t ohm(input logic [2:0] c);
        return c[2] ? OHM_300 : aotr_ohms_t'(5'h01 << c[1:0]);
    endfunction

    function automatic logic [27:0] exp_outs();
        return {sh[3][7:6], skew(sh[3][5:3]), skew(sh[3][2:0]), ohm(sh[4][5:3]),
            ohm(sh[4][2:0]), ohm(sh[5][5:3]), ohm(sh[5][2:0])};
    endfunction

    task automatic compare_rd(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %0t read %h want %h", $time, got, exp);
        end
    endtask

    task automatic compare_out(input logic [27:0] got, input logic [27:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %0t outputs %h want %h", $time, got, exp);
        end
    endtask

    // ****************************************************************
    // Monitor: oldest note against each result
    // ****************************************************************
    always @(posedge clk) begin
        if (rd_valid === 1'b1 && q_rd.size() > 0) compare_rd(rd_data, q_rd.pop_front());
        if (chk && q_out.size() > 0) compare_out({timing, term_a, term_b}, q_out.pop_front());
    end

    task automatic post();
        q_out.push_back(exp_outs());
        @(posedge clk);
        chk <= 1'b1;
        @(posedge clk);
        chk <= 1'b0;
    endtask

    // Mapped writes land in the shadow; bits 7:6 of 04/05 are not kept
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        aotr_host_model_inst.xfer({1'b0, a, d}, 16);
        if (a == `AOTR_ADDR_TIMING) sh[a] = d;
        else if (a == `AOTR_ADDR_TERM_A || a == `AOTR_ADDR_TERM_B) sh[a] = {2'b00, d[5:0]};
        post();
    endtask

    task automatic rd(input logic [6:0] a);
        q_rd.push_back(sh[a]);
        aotr_host_model_inst.xfer({1'b1, a, 8'h00}, 16);
    endtask

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #1500000;
        n_mismatch++;
        close_out();
    end

    initial begin
        int c;
        int k;
        for (k = 0; k < 128; k++) sh[k] = 8'h00;
        sh[3] = 8'h6d;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        post();
        rd(`AOTR_ADDR_TIMING);
        rd(`AOTR_ADDR_TERM_A);
        rd(`AOTR_ADDR_TERM_B);
        $display("test reset done");
        for (c = 0; c < 7; c++) begin
            wr(`AOTR_ADDR_TIMING, {2'(xs()), vcode(c), vcode(6 - c)});
            rd(`AOTR_ADDR_TIMING);
        end
        $display("test skew done");
        for (c = 0; c < 8; c++) begin
            wr(`AOTR_ADDR_TERM_A, {2'(xs()), 3'(c), 3'(c + 3)});
            wr(`AOTR_ADDR_TERM_B, {2'(xs()), 3'(c + 5), 3'(c)});
            rd(`AOTR_ADDR_TERM_A);
            rd(`AOTR_ADDR_TERM_B);
        end
        $display("test termination done");
        wr(7'h06, 8'(xs()));
        rd(7'h06);
        aotr_host_model_inst.xfer({1'b0, `AOTR_ADDR_TERM_A, 8'h3f}, 10);
        post();
        rd(`AOTR_ADDR_TERM_A);
        $display("test refusal done");
        close_out();
    end
endmodule

`default_nettype wire
